// >>> verilog/pfm_pkg.sv
// ----------------------------------------------------------------------------
// Shared constants for the pin function matrix.
// ----------------------------------------------------------------------------
package pfm_pkg;

    // Port geometry.
    localparam int NUM_PINS = 8;
    localparam int SEL_W = 5;
    localparam int DM_W = 3;
    localparam int ACT_FUNCS = 16;
    localparam int RET_FUNCS = 8;
    localparam int SEL_PER_REG = 4;
    localparam int SEL_STRIDE = 8;

    // Register byte offsets on the APB slave.
    localparam logic [7:0] OFF_OUT = 8'h00;
    localparam logic [7:0] OFF_IN = 8'h04;
    localparam logic [7:0] OFF_DRIVE_MODE = 8'h08;
    localparam logic [7:0] OFF_IN_EN = 8'h0C;
    localparam logic [7:0] OFF_OUT_CFG = 8'h10;
    localparam logic [7:0] OFF_SEL0 = 8'h14;
    localparam logic [7:0] OFF_SEL1 = 8'h18;
    localparam logic [7:0] OFF_OVT_STAT = 8'h1C;

    // Field positions inside the output configuration register.
    localparam int DRV_SEL_LSB = 0;
    localparam int SLOW_BIT = 8;

    // Values after reset.
    localparam logic [7:0] RST_OUT = 8'h00;
    localparam logic [23:0] RST_DRIVE_MODE = 24'h000000;
    localparam logic [7:0] RST_IN_EN = 8'h00;
    localparam logic [SEL_W-1:0] RST_SEL = 5'h00;
    localparam logic [1:0] RST_DRV_SEL = 2'h0;
    localparam logic RST_SLOW = 1'b0;

    // Pins that carry overvoltage protection.
    localparam logic [7:0] OVT_PIN_MASK = 8'hF0;

    // Select codes.
    localparam logic [SEL_W-1:0] SEL_GPIO = 5'h00;
    localparam logic [SEL_W-1:0] SEL_GPIO_FAB = 5'h01;
    localparam logic [SEL_W-1:0] SEL_FAB_FAB = 5'h02;
    localparam logic [SEL_W-1:0] SEL_FAB_GPIO = 5'h03;
    localparam logic [SEL_W-1:0] SEL_ABUS1 = 5'h04;
    localparam logic [SEL_W-1:0] SEL_ABUS2 = 5'h05;
    localparam logic [SEL_W-1:0] SEL_ABUS1_FAB = 5'h06;
    localparam logic [SEL_W-1:0] SEL_ABUS2_FAB = 5'h07;
    localparam logic [SEL_W-1:0] SEL_ACT_LO = 5'h08;
    localparam logic [SEL_W-1:0] SEL_ACT_HI = 5'h0B;
    localparam logic [SEL_W-1:0] SEL_RET_LO = 5'h0C;
    localparam logic [SEL_W-1:0] SEL_RET_HI = 5'h0F;
    localparam logic [SEL_W-1:0] SEL_ACT2_LO = 5'h10;
    localparam logic [SEL_W-1:0] SEL_ACT2_HI = 5'h1B;
    localparam logic [SEL_W-1:0] SEL_RET2_LO = 5'h1C;
    localparam logic [SEL_W-1:0] SEL_RET2_HI = 5'h1F;

    // Output-style codes.
    localparam logic [DM_W-1:0] DM_HIZ = 3'h0;
    localparam logic [DM_W-1:0] DM_RSVD = 3'h1;
    localparam logic [DM_W-1:0] DM_PULL_UP = 3'h2;
    localparam logic [DM_W-1:0] DM_PULL_DN = 3'h3;
    localparam logic [DM_W-1:0] DM_OD_LOW = 3'h4;
    localparam logic [DM_W-1:0] DM_OD_HIGH = 3'h5;
    localparam logic [DM_W-1:0] DM_STRONG = 3'h6;
    localparam logic [DM_W-1:0] DM_PULL_BOTH = 3'h7;

endpackage

// >>> verilog/pfm_sync.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Two-stage synchroniser for pin-side levels.
// ----------------------------------------------------------------------------
module pfm_sync #(
    parameter int W = 8
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_r;

    // Only the second stage reads the first, to keep metastability contained.
    always_ff @(posedge clock) begin
        if (rst) begin
            meta_r <= '0;
            sync_out <= '0;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule

// >>> verilog/pfm_drive.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Output-style decode for one pin driver.
// ----------------------------------------------------------------------------
module pfm_drive
    import pfm_pkg::*;
(
    input wire logic [DM_W-1:0] drive_mode,
    input wire logic val,
    input wire logic en,
    input wire logic overvolt,
    output logic strong_oe,
    output logic weak_up,
    output logic weak_dn
);
    // Strong and weak drivers per style; an overvoltage tristates all of them.
    always_comb begin
        strong_oe = 1'b0;
        weak_up = 1'b0;
        weak_dn = 1'b0;
        // RL20 overvoltage tristate.
        if (en && !overvolt) begin
            unique case (drive_mode)
                DM_HIZ: begin
                end
                // RL15 strong both states.
                DM_RSVD, DM_STRONG: strong_oe = 1'b1;
                DM_PULL_UP: begin
                    weak_up = val;
                    strong_oe = !val;
                end
                DM_PULL_DN: begin
                    weak_dn = !val;
                    strong_oe = val;
                end
                // RL14 open-drain one state.
                DM_OD_LOW: strong_oe = !val;
                DM_OD_HIGH: strong_oe = val;
                // RL16 weak both states.
                DM_PULL_BOTH: begin
                    weak_up = val;
                    weak_dn = !val;
                end
            endcase
        end
    end
endmodule

// >>> verilog/pfm_matrix.sv
`timescale 1ns/1ps
// Operation
// RL1 - Per-pin select picks one of 32 connections.
// RL2 - Code 0: register value, enable one, register input.
// RL3 - Code 1: register value, fabric enable.
// RL4 - Codes 2 and 3 route through the fabric.
// RL5 - Code 4 closes first analog switch.
// RL6 - Code 5 closes second analog switch.
// RL7 - Codes 6, 7: fabric value drives switch.
// RL8 - Codes 8-11 go to active functions 0-3.
// RL9 - Codes 12-15 go to retention functions 0-3.
// RL10 - Remaining codes reach higher active, retention functions.
// RL11 - Reset leaves pins high impedance, input off.
// RL12 - Output-style field encodes eight driver styles.
// RL13 - Software sets data bit for pull direction.
// RL14 - Open drain drives only one data state.
// RL15 - Strong style drives both states.
// RL16 - Pull-both style drives weakly both ways.
// RL17 - Slow-edge bit resets cleared, fast edges.
// RL18 - Strength field picks full, half, quarter, eighth.
// RL19 - Software keeps full strength with slow edges.
// RL20 - Overvoltage on tolerant pins tristates driver.
// RL21 - Software parks unused pins in high impedance.
// RL22 - Five-bit select, purely combinational multiplexing.
module pfm_matrix
    import pfm_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [pfm_pkg::NUM_PINS-1:0] pad_in,
    input wire logic [pfm_pkg::NUM_PINS-1:0] ovt_detect,
    output logic [pfm_pkg::NUM_PINS-1:0] pad_out,
    output logic [pfm_pkg::NUM_PINS-1:0] pad_oe,
    output logic [pfm_pkg::NUM_PINS-1:0] pad_pull_up,
    output logic [pfm_pkg::NUM_PINS-1:0] pad_pull_down,
    output logic [pfm_pkg::NUM_PINS-1:0] analog_bus_first_sw,
    output logic [pfm_pkg::NUM_PINS-1:0] analog_bus_second_sw,
    output logic slow_edge,
    output logic [1:0] drive_strength,
    input wire logic [pfm_pkg::NUM_PINS-1:0] fab_out,
    input wire logic [pfm_pkg::NUM_PINS-1:0] fab_oe,
    output logic [pfm_pkg::NUM_PINS-1:0] fab_in,
    input wire logic [pfm_pkg::NUM_PINS-1:0][pfm_pkg::ACT_FUNCS-1:0] act_out,
    input wire logic [pfm_pkg::NUM_PINS-1:0][pfm_pkg::ACT_FUNCS-1:0] act_oe,
    output logic [pfm_pkg::NUM_PINS-1:0] act_in,
    input wire logic [pfm_pkg::NUM_PINS-1:0][pfm_pkg::RET_FUNCS-1:0] ret_out,
    input wire logic [pfm_pkg::NUM_PINS-1:0][pfm_pkg::RET_FUNCS-1:0] ret_oe,
    output logic [pfm_pkg::NUM_PINS-1:0] ret_in
);
    import pfm_pkg::*;

    // ------------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------------

    // Merge write data into an old word under the byte strobes.
    function automatic logic [31:0] apply_strb(input logic [31:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = wd[8*b +: 8];
            end
        end
        return res;
    endfunction

    // True for every offset that maps to a register.
    function automatic logic addr_mapped(input logic [7:0] a);
        return (a == OFF_OUT) || (a == OFF_IN) || (a == OFF_DRIVE_MODE) ||
               (a == OFF_IN_EN) || (a == OFF_OUT_CFG) || (a == OFF_SEL0) ||
               (a == OFF_SEL1) || (a == OFF_OVT_STAT);
    endfunction

    // Active function number: codes 8-11 give 0-3, codes 16-27 give 4-15.
    function automatic logic [3:0] act_index(input logic [SEL_W-1:0] c);
        logic [SEL_W-1:0] t;
        t = (c <= SEL_ACT_HI) ? c - SEL_ACT_LO : c - (SEL_ACT2_LO - 5'h04);
        return t[3:0];
    endfunction

    // Retention function number: 12-15 give 0-3, 28-31 give 4-7.
    function automatic logic [2:0] ret_index(input logic [SEL_W-1:0] c);
        logic [SEL_W-1:0] t;
        t = (c <= SEL_RET_HI) ? c - SEL_RET_LO : c - (SEL_RET2_LO - 5'h04);
        return t[2:0];
    endfunction

    // ------------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------------
    logic [7:0] port_out_data_r;
    logic [NUM_PINS-1:0][DM_W-1:0] port_output_config_r;
    logic [7:0] in_en_r;
    logic [NUM_PINS-1:0][SEL_W-1:0] pin_select_code_r;
    logic slow_r;
    logic [1:0] drv_sel_r;
    logic [7:0] in_r;
    logic [7:0] in_sync;
    logic [7:0] ovt_sync;
    logic [31:0] prdata_nxt;
    logic wr_en;
    logic setup;
    logic [31:0] cfg_out_word;
    logic [31:0] cfg_out_new;
    logic [31:0] dm_new;
    logic [31:0] out_new;
    logic [31:0] in_en_new;

    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite && pready && addr_mapped(paddr);
    assign cfg_out_word = {23'h000000, slow_r, 6'h00, drv_sel_r};
    assign cfg_out_new = apply_strb(cfg_out_word, pwdata, pstrb);
    assign dm_new = apply_strb({8'h00, port_output_config_r}, pwdata, pstrb);
    assign out_new = apply_strb({24'h000000, port_out_data_r}, pwdata, pstrb);
    assign in_en_new = apply_strb({24'h000000, in_en_r}, pwdata, pstrb);

    // Data register and input-enable register.
    always_ff @(posedge clock) begin
        if (rst) begin
            port_out_data_r <= RST_OUT;
            in_en_r <= RST_IN_EN;
        end else if (wr_en && paddr == OFF_OUT) begin
            port_out_data_r <= out_new[7:0];
        end else if (wr_en && paddr == OFF_IN_EN) begin
            in_en_r <= in_en_new[7:0];
        end
    end

    // Output style per pin; reset parks every pin in high impedance.
    always_ff @(posedge clock) begin
        // RL11 reset state.
        if (rst) begin
            port_output_config_r <= RST_DRIVE_MODE;
        // RL12 style field.
        end else if (wr_en && paddr == OFF_DRIVE_MODE) begin
            port_output_config_r <= dm_new[23:0];
        end
    end

    // Port-wide edge rate and strength; the combination with slow edges and
    // reduced strength is not blocked, software is trusted to avoid it.
    always_ff @(posedge clock) begin
        // RL17 slow bit reset.
        if (rst) begin
            slow_r <= RST_SLOW;
            drv_sel_r <= RST_DRV_SEL;
        // RL18 strength select.
        end else if (wr_en && paddr == OFF_OUT_CFG) begin
            slow_r <= cfg_out_new[SLOW_BIT];
            drv_sel_r <= cfg_out_new[DRV_SEL_LSB +: 2];
        end
    end

    // Select codes, four pins per register, one byte lane per pin.
    always_ff @(posedge clock) begin
        // RL22 five-bit select.
        if (rst) begin
            for (int i = 0; i < NUM_PINS; i++) begin
                pin_select_code_r[i] <= RST_SEL;
            end
        end else if (wr_en && (paddr == OFF_SEL0 || paddr == OFF_SEL1)) begin
            for (int i = 0; i < SEL_PER_REG; i++) begin
                if (pstrb[i]) begin
                    pin_select_code_r[(paddr == OFF_SEL1 ? SEL_PER_REG : 0) + i]
                        <= pwdata[SEL_STRIDE*i +: SEL_W];
                end
            end
        end
    end

    // Port-wide driver controls come straight from their registers.
    assign slow_edge = slow_r;
    assign drive_strength = drv_sel_r;

    // ------------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------------

    // Read data is assembled in the setup cycle so it is ready, from a
    // flip-flop, in the access cycle; the slave never inserts wait states.
    always_comb begin
        prdata_nxt = 32'h00000000;
        for (int i = 0; i < SEL_PER_REG; i++) begin
            if (paddr == OFF_SEL0) begin
                prdata_nxt[SEL_STRIDE*i +: SEL_W] = pin_select_code_r[i];
            end
            if (paddr == OFF_SEL1) begin
                prdata_nxt[SEL_STRIDE*i +: SEL_W] =
                    pin_select_code_r[SEL_PER_REG + i];
            end
        end
        unique case (paddr)
            OFF_OUT: prdata_nxt[7:0] = port_out_data_r;
            OFF_IN: prdata_nxt[7:0] = in_r;
            OFF_DRIVE_MODE: prdata_nxt[23:0] = port_output_config_r;
            OFF_IN_EN: prdata_nxt[7:0] = in_en_r;
            OFF_OUT_CFG: prdata_nxt = cfg_out_word;
            OFF_OVT_STAT: prdata_nxt[7:0] = ovt_sync & OVT_PIN_MASK;
            default: begin
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
            pready <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (setup) begin
                prdata <= pwrite ? 32'h00000000 : prdata_nxt;
                pslverr <= !addr_mapped(paddr);
            end
        end
    end

    // ------------------------------------------------------------------------
    // Pin side: synchronisers, input capture, multiplexer, drivers
    // ------------------------------------------------------------------------
    logic [NUM_PINS-1:0] pin_val;
    logic [NUM_PINS-1:0] pin_en;
    logic [NUM_PINS-1:0] to_reg;
    logic [NUM_PINS-1:0] in_val;

    pfm_sync #(.W(NUM_PINS)) u_pad_sync (
        .clock(clock),
        .rst(rst),
        .async_in(pad_in),
        .sync_out(in_sync)
    );

    pfm_sync #(.W(NUM_PINS)) u_ovt_sync (
        .clock(clock),
        .rst(rst),
        .async_in(ovt_detect),
        .sync_out(ovt_sync)
    );

    // A disabled input buffer reads as zero everywhere.
    assign in_val = in_sync & in_en_r;

    // Pins routed elsewhere leave their bit of the input register at zero.
    always_ff @(posedge clock) begin
        if (rst) begin
            in_r <= 8'h00;
        end else begin
            in_r <= in_val & to_reg;
        end
    end

    // Select-code multiplexer; no flip-flop in the path, so a peripheral drives
    // the pin with no added latency; pin levels reach it after the two synchroniser stages.
    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            pin_val[i] = port_out_data_r[i];
            pin_en[i] = 1'b1;
            to_reg[i] = 1'b0;
            fab_in[i] = 1'b0;
            act_in[i] = 1'b0;
            ret_in[i] = 1'b0;
            analog_bus_first_sw[i] = 1'b0;
            analog_bus_second_sw[i] = 1'b0;
            // RL1 one connection per pin.
            unique case (pin_select_code_r[i]) inside
                // RL2 register connection.
                SEL_GPIO: to_reg[i] = 1'b1;
                // RL3 fabric enable.
                SEL_GPIO_FAB: begin
                    pin_en[i] = fab_oe[i];
                    to_reg[i] = 1'b1;
                end
                // RL4 fabric routing.
                SEL_FAB_FAB: begin
                    pin_val[i] = fab_out[i];
                    pin_en[i] = fab_oe[i];
                    fab_in[i] = in_val[i];
                end
                SEL_FAB_GPIO: begin
                    pin_val[i] = fab_out[i];
                    pin_en[i] = port_out_data_r[i];
                    fab_in[i] = in_val[i];
                end
                // RL5 first switch closed.
                SEL_ABUS1: begin
                    to_reg[i] = 1'b1;
                    analog_bus_first_sw[i] = 1'b1;
                end
                // RL6 second switch closed.
                SEL_ABUS2: begin
                    to_reg[i] = 1'b1;
                    analog_bus_second_sw[i] = 1'b1;
                end
                // RL7 fabric-switched buses.
                SEL_ABUS1_FAB, SEL_ABUS2_FAB: begin
                    pin_en[i] = !fab_oe[i];
                    to_reg[i] = 1'b1;
                    analog_bus_first_sw[i] =
                        (pin_select_code_r[i] == SEL_ABUS1_FAB) && fab_out[i];
                    analog_bus_second_sw[i] =
                        (pin_select_code_r[i] == SEL_ABUS2_FAB) && fab_out[i];
                end
                // RL8 low active functions.
                // RL10 high active functions.
                [SEL_ACT_LO:SEL_ACT_HI], [SEL_ACT2_LO:SEL_ACT2_HI]: begin
                    pin_val[i] = act_out[i][act_index(pin_select_code_r[i])];
                    pin_en[i] = act_oe[i][act_index(pin_select_code_r[i])];
                    act_in[i] = in_val[i];
                end
                // RL9 low retention functions.
                // RL10 high retention functions.
                default: begin
                    pin_val[i] = ret_out[i][ret_index(pin_select_code_r[i])];
                    pin_en[i] = ret_oe[i][ret_index(pin_select_code_r[i])];
                    ret_in[i] = in_val[i];
                end
            endcase
        end
    end

    assign pad_out = pin_val;

    // One style decoder per pin.
    for (genvar g = 0; g < NUM_PINS; g++) begin : g_drv
        pfm_drive u_drive (
            .drive_mode(port_output_config_r[g]),
            .val(pin_val[g]),
            .en(pin_en[g]),
            .overvolt(ovt_sync[g] && OVT_PIN_MASK[g]),
            .strong_oe(pad_oe[g]),
            .weak_up(pad_pull_up[g]),
            .weak_dn(pad_pull_down[g])
        );
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    a_gpio_strong_drive: assert property (@(posedge clock) disable iff (rst) // RL2
        (pin_select_code_r[0] == SEL_GPIO &&
         port_output_config_r[0] == DM_STRONG)
        |-> pad_oe[0] && pad_out[0] == port_out_data_r[0])
        else $error("code 0 strong pin not driven from data register");

    a_fabric_enable: assert property (@(posedge clock) disable iff (rst) // RL3
        (pin_select_code_r[1] == SEL_GPIO_FAB &&
         port_output_config_r[1] == DM_STRONG)
        |-> pad_oe[1] == fab_oe[1])
        else $error("code 1 enable does not follow fabric");

    a_fabric_input: assert property (@(posedge clock) disable iff (rst) // RL4
        (pin_select_code_r[2] == SEL_FAB_FAB && in_en_r[2])
        ##2 (pin_select_code_r[2] == SEL_FAB_FAB && in_en_r[2])
        |-> fab_in[2] == $past(pad_in[2], 2))
        else $error("fabric input not two stages behind pad");

    a_abus_switches: assert property (@(posedge clock) disable iff (rst) // RL5
        (pin_select_code_r[3] == SEL_ABUS1)
        |-> analog_bus_first_sw[3] && !analog_bus_second_sw[3])
        else $error("code 4 switches wrong");

    a_fab_switch: assert property (@(posedge clock) disable iff (rst) // RL7
        (pin_select_code_r[4] == SEL_ABUS2_FAB)
        |-> analog_bus_second_sw[4] == fab_out[4] && !analog_bus_first_sw[4])
        else $error("code 7 switch not following fabric value");

    a_active_route: assert property (@(posedge clock) disable iff (rst) // RL10
        (pin_select_code_r[5] == SEL_ACT2_LO &&
         port_output_config_r[5] == DM_STRONG)
        |-> pad_out[5] == act_out[5][4] && pad_oe[5] == act_oe[5][4])
        else $error("code 16 not routed to active function 4");

    a_ret_route: assert property (@(posedge clock) disable iff (rst) // RL9
        (pin_select_code_r[6] == SEL_RET_LO)
        |-> pad_out[6] == ret_out[6][0] && !analog_bus_first_sw[6])
        else $error("code 12 not routed to retention function 0");

    a_reset_hiz: assert property (@(posedge clock) // RL11
        $fell(rst) |-> pad_oe == 8'h00 && pad_pull_up == 8'h00 &&
                       pad_pull_down == 8'h00 && in_en_r == 8'h00)
        else $error("pins not high impedance after reset");

    a_open_drain: assert property (@(posedge clock) disable iff (rst) // RL14
        (port_output_config_r[7] == DM_OD_LOW && !ovt_sync[7])
        |-> pad_oe[7] == (pin_en[7] && !pad_out[7]))
        else $error("drive-low style drives wrong state");

    a_ovt_tristate: assert property (@(posedge clock) disable iff (rst) // RL20
        ovt_detect[4] ##1 ovt_detect[4] ##1 ovt_detect[4]
        |-> pad_oe[4] == 1'b0 && !pad_pull_up[4] && !pad_pull_down[4])
        else $error("tolerant pin driven during overvoltage");

    a_apb_no_wait: assert property (@(posedge clock) disable iff (rst)
        (psel && penable) |-> pready)
        else $error("slave inserted a wait state");

    c_fab_switch: cover property (@(posedge clock) disable iff (rst)
        pin_select_code_r[0] == SEL_ABUS1_FAB && analog_bus_first_sw[0]);

    c_ret_high: cover property (@(posedge clock) disable iff (rst)
        pin_select_code_r[1] == SEL_RET2_HI && pad_oe[1]);

    c_ovt_hit: cover property (@(posedge clock) disable iff (rst)
        ovt_sync[4] && pin_en[4] && port_output_config_r[4] == DM_STRONG);

    c_unmapped: cover property (@(posedge clock) disable iff (rst)
        psel && penable && pslverr);
endmodule

// >>> test/pfm_far_model.sv
`timescale 1ns/1ps
// Fabric and peripheral sources on the far side of the matrix.
module pfm_far_model
    import pfm_pkg::*;
(
    input wire logic [1:0] pat,
    output logic [NUM_PINS-1:0] fab_out,
    output logic [NUM_PINS-1:0] fab_oe,
    output logic [NUM_PINS-1:0][ACT_FUNCS-1:0] act_out,
    output logic [NUM_PINS-1:0][ACT_FUNCS-1:0] act_oe,
    output logic [NUM_PINS-1:0][RET_FUNCS-1:0] ret_out,
    output logic [NUM_PINS-1:0][RET_FUNCS-1:0] ret_oe
);
    // Odd and even functions carry opposite values, so a wrong index shows.
    assign fab_out = {NUM_PINS{pat[0]}};
    assign fab_oe = {NUM_PINS{pat[1]}};
    assign act_out = {64{pat[0], !pat[0]}};
    assign act_oe = {128{pat[1]}};
    assign ret_out = {32{pat[0], !pat[0]}};
    assign ret_oe = {64{!pat[1]}};
endmodule

// >>> test/testbench.sv
`timescale 1ns/1ps
module testbench;
    import pfm_pkg::*;
    logic clock = 1'h0;
    logic rst = 1'h1;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [1:0] pat = 2'h0;
    logic [7:0] ovt_detect = 8'h00, pad_in = 8'h00;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, slow_edge;
    logic [1:0] drive_strength;
    logic [7:0] pad_out, pad_oe, pad_pull_up, pad_pull_down, fab_in;
    logic [7:0] analog_bus_first_sw, analog_bus_second_sw, act_in, ret_in;
    logic [7:0] fab_out, fab_oe;
    logic [7:0][15:0] act_out, act_oe;
    logic [7:0][7:0] ret_out, ret_oe;
    int errors = 0;
    int samples_checked = 0;

    pfm_far_model i_far (.pat, .fab_out, .fab_oe, .act_out, .act_oe,
        .ret_out, .ret_oe);
    pfm_matrix i_dut (.clock, .rst, .psel, .penable, .paddr, .pwrite,
        .pwdata, .pstrb(4'hF), .prdata, .pready, .pslverr,
        .pad_in, .ovt_detect, .pad_out, .pad_oe, .pad_pull_up,
        .pad_pull_down, .analog_bus_first_sw, .analog_bus_second_sw,
        .slow_edge, .drive_strength, .fab_out, .fab_oe, .fab_in,
        .act_out, .act_oe, .act_in, .ret_out, .ret_oe, .ret_in);

    // Free-running 250 MHz clock.
    initial forever #2 clock = ~clock;

    task automatic wrap_up;
        if (errors == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // One bus transfer; the request holds until pready is seen high, for at most 20 cycles.
    task automatic apb(input logic w, input logic [7:0] a, input int d);
        int n;
        @(posedge clock);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= 32'(d);
        @(posedge clock);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'h1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (pready !== 1'h1) begin
            errors++;
            wrap_up;
        end
    endtask

    function automatic logic [2:0] sty_exp(int s, logic d);
        case (s)
            0: return 3'h0;
            2: return d ? 3'h2 : 3'h4;
            3: return d ? 3'h4 : 3'h1;
            4: return {!d, 2'h0};
            5: return {d, 2'h0};
            7: return {1'h0, d, !d};
            default: return 3'h4;
        endcase
    endfunction

    function automatic logic [6:0] mux_exp(int c, logic [1:0] p, logic d);
        logic v, e, a, b, r;
        int f;
        {v, e, a, b} = {d, 3'h4};
        r = c > 11 && c < 16 || c > 27;
        f = c < 12 ? c - 8 : c == 15 ? 3 : c < 28 ? c - 12 : c - 24;
        case (c)
            0: e = 1'h1;
            1: e = p[1];
            2: {e, v} = p;
            3: {v, e} = {p[0], d};
            4: a = 1'h1;
            5: b = 1'h1;
            6: {e, a} = {!p[1], p[0]};
            7: {e, b} = {!p[1], p[0]};
            default: {v, e} = {p[0] ^ !f[0], p[1] ^ r};
        endcase
        return {v & e, e, a, b, c == 2 || c == 3, c > 7 && !r, r};
    endfunction

    // Main sequence: reset state, strength, styles, matrix, overvoltage.
    initial begin
        repeat (2) @(posedge clock);
        rst <= 1'h0;
        @(negedge clock);
        chk(32'(pad_oe), 32'h0);
        apb(1'h0, OFF_DRIVE_MODE, 0);
        chk(rd, 32'h0);
        chk(32'({slow_edge, drive_strength}), 32'h0);
        apb(1'h1, OFF_OUT_CFG, 3);
        @(negedge clock);
        chk(32'({slow_edge, drive_strength}), 32'h3);
        apb(1'h1, OFF_OUT_CFG, 32'h100);
        @(negedge clock);
        chk(32'({slow_edge, drive_strength}), 32'h4);
        apb(1'h0, 8'h20, 0);
        chk({rd[30:0], err}, 32'h1);
        apb(1'h1, OFF_IN_EN, 32'hFF);
        pad_in <= 8'hA5;
        repeat (4) @(posedge clock);
        apb(1'h0, OFF_IN, 0);
        chk(rd, 32'hA5);
        for (int k = 0; k < 16; k++) begin
            apb(1'h1, OFF_OUT, k % 2);
            apb(1'h1, OFF_DRIVE_MODE, k / 2 * 32'h249249);
            @(negedge clock);
            chk(32'({pad_oe[0], pad_pull_up[0], pad_pull_down[0]}), 32'(sty_exp(k / 2, k[0])));
        end
        apb(1'h1, OFF_DRIVE_MODE, 32'hDB6DB6);
        for (int c = 0; c < 32; c++) begin
            apb(1'h1, OFF_SEL0, c * 32'h01010101);
            apb(1'h1, OFF_SEL1, c * 32'h01010101);
            for (int k = 0; k < 8; k++) begin
                apb(1'h1, OFF_OUT, k / 4);
                pat <= 2'(k);
                @(negedge clock);
                chk(32'({pad_out[0] & pad_oe[0], pad_oe[0], analog_bus_first_sw[0], analog_bus_second_sw[0], fab_in[0], act_in[0], ret_in[0]}), 32'(mux_exp(c, 2'(k), k[2])));
            end
        end
        apb(1'h1, OFF_SEL1, 0);
        apb(1'h1, OFF_DRIVE_MODE, 32'h6000);
        apb(1'h1, OFF_OUT, 32'h10);
        ovt_detect <= 8'h11;
        repeat (3) @(posedge clock);
        @(negedge clock);
        chk(32'(pad_oe), 32'h0);
        apb(1'h0, OFF_OVT_STAT, 0);
        chk(rd, 32'h10);
        @(posedge clock);
        ovt_detect <= 8'h00;
        repeat (3) @(posedge clock);
        @(negedge clock);
        chk(32'(pad_oe), 32'h10);
        wrap_up;
    end
endmodule
